// [verif/host_model.sv]
`timescale 1ns/10ps
`include "pwr_event_map.svh"

// ==================================================================
// Host processor model: a plain Avalon-MM master.
module host_model (
   input wire logic i_ref_clk,
   input wire logic i_waitrequest,
   input wire logic [31:0] i_readdata,
   output logic [7:0] o_address,
   output logic o_read,
   output logic o_write,
   output logic [31:0] o_writedata,
   output logic [3:0] o_byteenable
);
   initial
   begin
      o_address = 8'h00;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0000_0000;
      o_byteenable = 4'h3;
   end

   // The request is held until waitrequest is seen low at a rising edge.
   task automatic access(input logic rnw, input logic [7:0] addr, input logic [15:0] data,
                         input logic [3:0] be);
      @(posedge i_ref_clk);
      o_address <= addr;
      o_read <= rnw;
      o_write <= !rnw;
      o_writedata <= {16'h0000, data};
      o_byteenable <= be;
      @(posedge i_ref_clk);
      while (i_waitrequest !== 1'b0)
      begin
         @(posedge i_ref_clk);
      end
      o_read <= 1'b0;
      o_write <= 1'b0;
   endtask : access

   task automatic host_wake;
      access(1'b1, `PEW_ADDR_GRR, 16'h0000, 4'h3);
      access(1'b1, `PEW_ADDR_GRR, 16'h0000, 4'h3);
   endtask : host_wake
endmodule : host_model

// [verif/tb.sv]
`timescale 1ns/10ps
`include "pwr_event_map.svh"

module tb;
   logic i_ref_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_soft_reset = 1'b0;
   logic i_line_energy = 1'b0;
   logic i_link_up = 1'b0;
   logic i_wake_packet = 1'b0;
   logic i_wake_frame = 1'b0;
   logic [7:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   logic power_event_output;
   logic irq;
   logic low_power;
   logic rx_tx_enable;
   logic power_saving;
   int failures = 0;
   int checked = 0;
   integer seed = 32'h0de1;
   logic [15:0] rnd;
   logic [15:0] expq[$];

   always #50 i_ref_clk = ~i_ref_clk;

   power_event_wake_controller #(.WAKE_UNIT_CYCLES(4), .SLEEP_UNIT_CYCLES(8))
   power_event_wake_controller_inst (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_soft_reset(i_soft_reset),
      .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
      .i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
      .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
      .i_line_energy(i_line_energy), .i_link_up(i_link_up), .i_wake_packet(i_wake_packet),
      .i_wake_frame(i_wake_frame), .o_pme(power_event_output), .o_irq(irq), .o_low_power(low_power),
      .o_rx_tx_enable(rx_tx_enable), .o_power_saving(power_saving)
   );

   host_model host_model_inst (
      .i_ref_clk(i_ref_clk), .i_waitrequest(waitrequest), .i_readdata(readdata),
      .o_address(address), .o_read(read), .o_write(write), .o_writedata(writedata),
      .o_byteenable(byteenable)
   );

   // ===============================================================
   // Comparison and verdict.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   // ===============================================================
   // Stimulus helpers.
   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host_model_inst.access(1'b0, a, d, 4'h3);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      expq.push_back(exp);
      host_model_inst.access(1'b1, a, 16'h0000, 4'h3);
   endtask : rd_chk

   task automatic wait_low(input logic lvl);
      for (int i = 0; i < 200 && low_power !== lvl; i++)
         @(posedge i_ref_clk);
   endtask : wait_low

   // Event codes: 1 link up, 2 sequence packet, 3 frame, 4 soft reset.
   task automatic pulse(input int e);
      @(posedge i_ref_clk);
      i_link_up <= (e == 1) | i_link_up;
      i_wake_packet <= (e == 2);
      i_wake_frame <= (e == 3);
      i_soft_reset <= (e == 4);
      @(posedge i_ref_clk);
      i_wake_packet <= 1'b0;
      i_wake_frame <= 1'b0;
      i_soft_reset <= 1'b0;
   endtask : pulse

   // ===============================================================
   // Read data are compared at the edge where the read completes.
   always @(posedge i_ref_clk)
   begin
      if (read === 1'b1 && waitrequest === 1'b0 && expq.size() > 0)
         check(readdata, {16'h0000, expq.pop_front()});
   end

   initial
   begin
      repeat (5000) @(posedge i_ref_clk);
      failures++;
      print_verdict();
   end

   // ===============================================================
   // Main sequence.
   initial
   begin
      repeat (12) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      cyc(2);
      check(power_event_output, 1'b1);
      check(rx_tx_enable, 1'b1);
      rd_chk(`PEW_ADDR_PMEC, 16'h0000);
      rd_chk(`PEW_ADDR_SWT, 16'h080c);
      wr(8'h40, 16'hffff);
      rd_chk(8'h40, 16'h0000);
      rnd = 16'($random(seed)) | 16'h0101;
      wr(`PEW_ADDR_SWT, rnd);
      rd_chk(`PEW_ADDR_SWT, rnd);
      host_model_inst.access(1'b0, `PEW_ADDR_SWT, 16'h03ff, 4'h2);
      rd_chk(`PEW_ADDR_SWT, {8'h03, rnd[7:0]});
      wr(`PEW_ADDR_PMEC, 16'h1f00);
      cyc(3);
      check(power_event_output, 1'b0);
      for (int e = 1; e < 4; e++)
      begin
         pulse(e);
         cyc(8);
         rd_chk(`PEW_ADDR_PMEC, 16'h1f00 | (16'h0004 << e));
         check(power_event_output, 1'b1);
         wr(`PEW_ADDR_PMEC, 16'h1f3c);
         cyc(3);
         check(power_event_output, 1'b0);
         rd_chk(`PEW_ADDR_PMEC, 16'h1f00);
      end
      rd_chk(`PEW_ADDR_ISR, 16'h0008);
      wr(`PEW_ADDR_IER, 16'h0008);
      cyc(3);
      check(irq, 1'b1);
      wr(`PEW_ADDR_IER, 16'h0000);
      cyc(3);
      check(irq, 1'b0);
      wr(`PEW_ADDR_ICLR, 16'h0008);
      rd_chk(`PEW_ADDR_ISR, 16'h0000);
      wr(`PEW_ADDR_IER, 16'h0004);
      wr(`PEW_ADDR_PMEC, 16'h1700);
      pulse(3);
      cyc(8);
      check(power_event_output, 1'b0);
      wr(`PEW_ADDR_PMEC, 16'h0800);
      cyc(3);
      check(power_event_output, 1'b0);
      wr(`PEW_ADDR_PMEC, 16'h0820);
      cyc(3);
      check(power_event_output, 1'b1);
      pulse(3);
      pulse(4);
      cyc(3);
      rd_chk(`PEW_ADDR_PMEC, 16'h0020);
      wr(`PEW_ADDR_PMEC, 16'h0023);
      cyc(3);
      check(power_saving, 1'b1);
      check(rx_tx_enable, 1'b1);
      wr(`PEW_ADDR_SWT, 16'h0201);
      wr(`PEW_ADDR_PMEC, 16'h11c1);
      wait_low(1'b1);
      check(low_power, 1'b1);
      check(rx_tx_enable, 1'b0);
      i_line_energy <= 1'b1;
      wait_low(1'b0);
      check(low_power, 1'b0);
      rd_chk(`PEW_ADDR_PMEC, 16'h11c4);
      check(power_event_output, 1'b1);
      check(irq, 1'b1);
      i_line_energy <= 1'b0;
      wr(`PEW_ADDR_PMEC, 16'h003c);
      wr(`PEW_ADDR_ICLR, 16'h0004);
      wr(`PEW_ADDR_PMEC, 16'h0001);
      wait_low(1'b1);
      check(low_power, 1'b1);
      host_model_inst.host_wake();
      cyc(3);
      check(low_power, 1'b0);
      rd_chk(`PEW_ADDR_PMEC, 16'h0000);
      wr(`PEW_ADDR_PMEC, 16'h5802);
      pulse(3);
      cyc(8);
      check(power_event_output, 1'b1);
      host_model_inst.host_wake();
      wr(`PEW_ADDR_PMEC, 16'h0020);
      wr(`PEW_ADDR_PMEC, 16'h5882);
      cyc(3);
      check(low_power, 1'b1);
      pulse(3);
      cyc(8);
      check(power_event_output, 1'b0);
      i_line_energy <= 1'b1;
      cyc(40);
      check(low_power, 1'b1);
      i_line_energy <= 1'b0;
      host_model_inst.host_wake();
      cyc(3);
      check(low_power, 1'b0);
      check(power_event_output, 1'b1);
      print_verdict();
   end
endmodule : tb

// [verilog/power_event_wake_controller.sv]
`timescale 1ns/10ps
`include "pwr_event_map.svh"

module power_event_wake_controller #(
   parameter int WAKE_UNIT_CYCLES = `PEW_WAKE_UNIT_CYC,
   parameter int SLEEP_UNIT_CYCLES = `PEW_SLEEP_UNIT_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_soft_reset,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_line_energy,
   input wire logic i_link_up,
   input wire logic i_wake_packet,
   input wire logic i_wake_frame,
   output logic o_pme,
   output logic o_irq,
   output logic o_low_power,
   output logic o_rx_tx_enable,
   output logic o_power_saving
);

   localparam logic [23:0] WAKE_UNIT = 24'(WAKE_UNIT_CYCLES - 1);
   localparam logic [23:0] SLEEP_UNIT = 24'(SLEEP_UNIT_CYCLES - 1);

   // ===============================================================
   // Avalon slave: one wait cycle, then a one-cycle answer.
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   logic take, rd_done, wr_done;
   logic [15:0] wdata;
   logic [15:0] rd_word;
   pwr_event_pkg::pmec_ctrl_t ctrl_reg, ctrl_next;
   pwr_event_pkg::sleep_wake_t swt_reg, swt_next;
   pwr_event_pkg::wake_evt_t evt_reg, evt_next;
   pwr_event_pkg::pwr_state_t state_reg, state_next;
   logic [1:0] isr_reg, isr_next;
   logic [1:0] ier_reg, ier_next;
   logic [23:0] pre_reg, pre_next;
   logic [7:0] unit_reg, unit_next;
   logic wake_cnt_reg, wake_cnt_next;
   assign take = (i_avs_read | i_avs_write) & wait_reg;
   assign rd_done = i_avs_read & ~wait_reg;
   assign wr_done = i_avs_write & ~wait_reg;
   assign wdata = i_avs_writedata[15:0];
   always_comb
   begin
      unique case (i_avs_address)
         `PEW_ADDR_PMEC: rd_word = {1'b0, ctrl_reg.delay_en, 1'b0, ctrl_reg.polarity,
                                    ctrl_reg.out_en, ctrl_reg.auto_wake,
                                    ctrl_reg.wake_normal, evt_reg, ctrl_reg.mode};
         `PEW_ADDR_SWT: rd_word = swt_reg;
         `PEW_ADDR_ISR: rd_word = {12'h000, isr_reg, 2'b00};
         `PEW_ADDR_IER: rd_word = {12'h000, ier_reg, 2'b00};
         default: rd_word = 16'h0000;
      endcase
   end

   always_comb
   begin
      wait_next = ~take;
      rdata_next = rdata_reg;
      if (take && i_avs_read)
      begin
         rdata_next = {16'h0000, rd_word};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_avs_waitrequest = wait_reg;
   assign o_avs_readdata = rdata_reg;

   // ===============================================================
   // Pin synchronisers and link edge detection.
   logic energy_s1, energy_s2, link_s1, link_s2, link_d;
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         energy_s1 <= 1'b0;
         energy_s2 <= 1'b0;
         link_s1 <= 1'b0;
         link_s2 <= 1'b0;
         link_d <= 1'b0;
      end
      else
      begin
         energy_s1 <= i_line_energy;
         energy_s2 <= energy_s1;
         link_s1 <= i_link_up;
         link_s2 <= link_s1;
         link_d <= link_s2;
      end
   end

   // ===============================================================
   // Power state machine, timers and event status.
   logic timing, unit_wrap, fire, low_state, pmec_wr;
   logic [7:0] limit_units;
   logic [3:0] evt_clr;
   pwr_event_pkg::wake_evt_t evt_set;

   assign low_state = (state_reg == pwr_event_pkg::ST_ED_LOW)
                      | (state_reg == pwr_event_pkg::ST_SOFT_DOWN);
   assign pmec_wr = wr_done && (i_avs_address == `PEW_ADDR_PMEC);
   assign timing = ((state_reg == pwr_event_pkg::ST_ED_LOW) & energy_s2)
                   | ((state_reg == pwr_event_pkg::ST_ED_AWAKE) & ~energy_s2);
   assign limit_units = (state_reg == pwr_event_pkg::ST_ED_LOW) ? swt_reg.wake_time
                                                                : swt_reg.sleep_time;
   assign unit_wrap = (state_reg == pwr_event_pkg::ST_ED_LOW) ? (pre_reg == WAKE_UNIT)
                                                              : (pre_reg == SLEEP_UNIT);
   assign fire = timing & unit_wrap & ((unit_reg + 8'h01) == limit_units);

   always_comb
   begin
      ctrl_next = ctrl_reg;
      swt_next = swt_reg;
      ier_next = ier_reg;
      state_next = state_reg;
      pre_next = 24'h00_0000;
      unit_next = 8'h00;
      wake_cnt_next = wake_cnt_reg;
      evt_set = '0;
      evt_clr = 4'h0;
      evt_set.link_up = link_s2 & ~link_d;
      evt_set.seq_pkt = i_wake_packet;
      evt_set.frame = i_wake_frame;
      if (timing && !(unit_reg == limit_units))
      begin
         pre_next = unit_wrap ? 24'h00_0000 : pre_reg + 24'h00_0001;
         unit_next = unit_wrap ? unit_reg + 8'h01 : unit_reg;
      end
      else if (timing)
      begin
         unit_next = unit_reg;
      end
      if (fire && state_reg == pwr_event_pkg::ST_ED_LOW)
      begin
         evt_set.energy = 1'b1;
         if (ctrl_reg.auto_wake)
         begin
            state_next = pwr_event_pkg::ST_ED_AWAKE;
            if (ctrl_reg.wake_normal)
            begin
               state_next = pwr_event_pkg::ST_RUN;
               ctrl_next.mode = pwr_event_pkg::MODE_NORMAL;
            end
         end
      end
      else if (fire)
      begin
         state_next = pwr_event_pkg::ST_ED_LOW;
      end
      if (rd_done || wr_done)
      begin
         wake_cnt_next = 1'b0;
         if (rd_done && i_avs_address == `PEW_ADDR_GRR && low_state)
         begin
            wake_cnt_next = ~wake_cnt_reg;
            if (wake_cnt_reg)
            begin
               state_next = pwr_event_pkg::ST_RUN;
               ctrl_next.mode = pwr_event_pkg::MODE_NORMAL;
            end
         end
      end
      if (pmec_wr)
      begin
         if (i_avs_byteenable[1])
         begin
            ctrl_next.delay_en = wdata[`PEW_PMEC_DELAY];
            ctrl_next.polarity = wdata[`PEW_PMEC_POL];
            ctrl_next.out_en = wdata[`PEW_PMEC_OUTEN_LSB +: 4];
         end
         if (i_avs_byteenable[0])
         begin
            ctrl_next.auto_wake = wdata[`PEW_PMEC_AUTO];
            ctrl_next.wake_normal = wdata[`PEW_PMEC_WNORM];
            evt_clr = wdata[`PEW_PMEC_EVT_LSB +: 4];
            ctrl_next.mode = pwr_event_pkg::pwr_mode_t'(wdata[`PEW_PMEC_MODE_LSB +: 2]);
            unique case (ctrl_next.mode)
               pwr_event_pkg::MODE_ENERGY: state_next = pwr_event_pkg::ST_ED_AWAKE;
               pwr_event_pkg::MODE_SOFT_DOWN: state_next = pwr_event_pkg::ST_SOFT_DOWN;
               pwr_event_pkg::MODE_NORMAL, pwr_event_pkg::MODE_SAVING:
                  state_next = pwr_event_pkg::ST_RUN;
            endcase
         end
      end
      if (wr_done && i_avs_address == `PEW_ADDR_SWT)
      begin
         if (i_avs_byteenable[1])
         begin
            swt_next.wake_time = wdata[`PEW_SWT_WAKE_LSB +: 8];
         end
         if (i_avs_byteenable[0])
         begin
            swt_next.sleep_time = wdata[`PEW_SWT_SLEEP_LSB +: 8];
         end
      end
      if (wr_done && i_avs_address == `PEW_ADDR_IER && i_avs_byteenable[0])
      begin
         ier_next = wdata[`PEW_ISR_LINK:`PEW_ISR_ENERGY];
      end
      // Event status survives the soft reset.
      if (i_soft_reset)
      begin
         ctrl_next = `PEW_PMEC_RST;
         swt_next = {`PEW_WAKE_TIME_RST, `PEW_SLEEP_TIME_RST};
         state_next = pwr_event_pkg::ST_RUN;
         wake_cnt_next = 1'b0;
      end
      // A new event wins over its clear.
      evt_next = (evt_reg & ~evt_clr) | evt_set;
      isr_next = isr_reg;
      if (wr_done && i_avs_address == `PEW_ADDR_ICLR && i_avs_byteenable[0])
      begin
         isr_next = isr_reg & ~wdata[`PEW_ISR_LINK:`PEW_ISR_ENERGY];
      end
      isr_next = isr_next | {evt_set.link_up, evt_set.energy};
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ctrl_reg <= `PEW_PMEC_RST;
         swt_reg <= {`PEW_WAKE_TIME_RST, `PEW_SLEEP_TIME_RST};
         evt_reg <= '0;
         isr_reg <= 2'b00;
         ier_reg <= 2'b00;
         state_reg <= pwr_event_pkg::ST_RUN;
         pre_reg <= 24'h00_0000;
         unit_reg <= 8'h00;
         wake_cnt_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         swt_reg <= swt_next;
         evt_reg <= evt_next;
         isr_reg <= isr_next;
         ier_reg <= ier_next;
         state_reg <= state_next;
         pre_reg <= pre_next;
         unit_reg <= unit_next;
         wake_cnt_reg <= wake_cnt_next;
      end
   end

   // ===============================================================
   // Registered outputs.
   logic pme_next, irq_next, low_next, rxtx_next, saving_next, pme_active, pme_hold;

   always_comb
   begin
      pme_active = |(evt_reg & ctrl_reg.out_en);
      pme_hold = ctrl_reg.delay_en & ctrl_reg.auto_wake & low_state;
      pme_next = ctrl_reg.polarity ? (pme_active & ~pme_hold) : ~(pme_active & ~pme_hold);
      irq_next = |(isr_reg & ier_reg);
      low_next = low_state;
      rxtx_next = ~low_state;
      saving_next = (ctrl_reg.mode == pwr_event_pkg::MODE_SAVING);
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pme <= 1'b1;
         o_irq <= 1'b0;
         o_low_power <= 1'b0;
         o_rx_tx_enable <= 1'b0;
         o_power_saving <= 1'b0;
      end
      else
      begin
         o_pme <= pme_next;
         o_irq <= irq_next;
         o_low_power <= low_next;
         o_rx_tx_enable <= rxtx_next;
         o_power_saving <= saving_next;
      end
   end

   // ===============================================================
   // Assertions.
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   property p_pme_idle;
      (evt_reg & ctrl_reg.out_en) == 4'h0 |=> o_pme == ~$past(ctrl_reg.polarity);
   endproperty
   a_pme_idle: assert property (p_pme_idle) else $error("Event output active without event.");
   property p_pme_hold;
      ctrl_reg.delay_en && ctrl_reg.auto_wake && low_state
         |=> o_pme == ~$past(ctrl_reg.polarity);
   endproperty
   a_pme_hold: assert property (p_pme_hold) else $error("Event output not delayed.");
   property p_pme_fire;
      (|(evt_reg & ctrl_reg.out_en)) && !(ctrl_reg.auto_wake && ctrl_reg.delay_en && low_state)
         |=> o_pme == $past(ctrl_reg.polarity);
   endproperty
   a_pme_fire: assert property (p_pme_fire) else $error("Enabled event not on output.");
   property p_pme_clear;
      pmec_wr && i_avs_byteenable[0] && wdata[`PEW_PMEC_EVT_LSB +: 4] == 4'hF
         && evt_set == 4'h0 && !i_soft_reset ##1 evt_set == 4'h0 && !pmec_wr ##1 1'b1
         |-> o_pme == ~$past(ctrl_reg.polarity);
   endproperty
   a_pme_clear: assert property (p_pme_clear) else $error("Output stays after clear.");
   property p_isr_energy;
      $rose(evt_reg.energy) |-> isr_reg[0];
   endproperty
   a_isr_energy: assert property (p_isr_energy) else $error("Energy event missed status.");
   property p_evt_keep;
      $fell(evt_reg.link_up) |-> $past(pmec_wr && i_avs_byteenable[0] && wdata[3]);
   endproperty
   a_evt_keep: assert property (p_evt_keep) else $error("Status cleared without write.");
   property p_soft_down;
      state_reg == pwr_event_pkg::ST_SOFT_DOWN && !rd_done && !wr_done && !i_soft_reset
         |=> state_reg == pwr_event_pkg::ST_SOFT_DOWN;
   endproperty
   a_soft_down: assert property (p_soft_down) else $error("Soft power down left.");
   property p_host_wake;
      rd_done && i_avs_address == `PEW_ADDR_GRR && low_state && wake_cnt_reg && !i_soft_reset
         |=> state_reg == pwr_event_pkg::ST_RUN ##1 o_rx_tx_enable;
   endproperty
   a_host_wake: assert property (p_host_wake) else $error("Host wake failed.");
   property p_line_wake;
      fire && state_reg == pwr_event_pkg::ST_ED_LOW && ctrl_reg.auto_wake
         && ctrl_reg.wake_normal && !pmec_wr && !i_soft_reset
         |=> state_reg == pwr_event_pkg::ST_RUN && ctrl_reg.mode == pwr_event_pkg::MODE_NORMAL;
   endproperty
   a_line_wake: assert property (p_line_wake) else $error("No switch to normal.");
   property p_go_sleep;
      $past(state_reg) == pwr_event_pkg::ST_ED_AWAKE && state_reg == pwr_event_pkg::ST_ED_LOW
         |-> $past(fire);
   endproperty
   a_go_sleep: assert property (p_go_sleep) else $error("Early entry to low power.");
   property p_bus_one;
      !o_avs_waitrequest |=> o_avs_waitrequest;
   endproperty
   a_bus_one: assert property (p_bus_one) else $error("Wait low longer than one cycle.");
   c_line_wake: cover property (fire && state_reg == pwr_event_pkg::ST_ED_LOW);
   c_host_wake: cover property (rd_done && low_state && wake_cnt_reg);
   c_pme_on: cover property ($changed(o_pme) && evt_reg != 4'h0);

endmodule : power_event_wake_controller

// [verilog/pwr_event_map.svh]
`ifndef PWR_EVENT_MAP_SVH
`define PWR_EVENT_MAP_SVH

// ==================================================================
// Register word addresses on the Avalon slave.
`define PEW_ADDR_PMEC 8'hD4
`define PEW_ADDR_SWT 8'hD6
`define PEW_ADDR_GRR 8'h10
`define PEW_ADDR_ISR 8'h12
`define PEW_ADDR_IER 8'h14
`define PEW_ADDR_ICLR 8'h16

// ==================================================================
// Field positions.
`define PEW_PMEC_DELAY 14
`define PEW_PMEC_POL 12
`define PEW_PMEC_OUTEN_LSB 8
`define PEW_PMEC_AUTO 7
`define PEW_PMEC_WNORM 6
`define PEW_PMEC_EVT_LSB 2
`define PEW_PMEC_MODE_LSB 0
`define PEW_SWT_WAKE_LSB 8
`define PEW_SWT_SLEEP_LSB 0
`define PEW_ISR_ENERGY 2
`define PEW_ISR_LINK 3

// ==================================================================
// Reset values.
`define PEW_WAKE_TIME_RST 8'h08
`define PEW_SLEEP_TIME_RST 8'h0C
`define PEW_PMEC_RST 10'h000

// ==================================================================
// Timing.
`define PEW_CLK_HZ 10000000
`define PEW_WAKE_UNIT_MS 16
`define PEW_SLEEP_UNIT_S 1
`define PEW_WAKE_UNIT_CYC (`PEW_CLK_HZ / 1000 * `PEW_WAKE_UNIT_MS)
`define PEW_SLEEP_UNIT_CYC (`PEW_CLK_HZ * `PEW_SLEEP_UNIT_S)

`endif

// [verilog/pwr_event_pkg.sv]
package pwr_event_pkg;

   // ===============================================================
   // Power management mode field, in field encoding order.
   typedef enum logic [1:0] {MODE_NORMAL, MODE_ENERGY, MODE_SOFT_DOWN, MODE_SAVING} pwr_mode_t;

   // ===============================================================
   // Internal power states.
   typedef enum logic [1:0] {ST_RUN, ST_ED_AWAKE, ST_ED_LOW, ST_SOFT_DOWN} pwr_state_t;

   typedef struct packed {
      logic delay_en;
      logic polarity;
      logic [3:0] out_en;
      logic auto_wake;
      logic wake_normal;
      pwr_mode_t mode;
   } pmec_ctrl_t;

   typedef struct packed {
      logic frame;
      logic seq_pkt;
      logic link_up;
      logic energy;
   } wake_evt_t;

   typedef struct packed {
      logic [7:0] wake_time;
      logic [7:0] sleep_time;
   } sleep_wake_t;

endpackage : pwr_event_pkg
